// ---- rtl/acw_cc_unit.sv ----
// acw_cc_unit: encodes boolean and compare outcomes into a condition code and
// tests the present code against a branch mask. purely combinational.
// assumes: at most one of bool_valid and cmp_valid per cycle; compare wins if both.
module acw_cc_unit
    import acw_pkg::*;
(
    input  wire logic       bool_valid,  // boolean result offered
    input  wire logic       bool_true,   // boolean outcome
    input  wire logic       cmp_valid,   // comparison result offered
    input  wire logic       cmp_gt,      // operand a greater
    input  wire logic       cmp_eq,      // operands equal
    input  wire logic       cmp_lt,      // operand a less; none set means unordered
    input  wire logic [2:0] cc_now,      // code presently held
    input  wire logic [2:0] test_mask,   // branch condition mask
    output logic            cc_write,    // a new code is to be stored
    output logic      [2:0] cc_code,     // the new code
    output logic            test_hit     // present code meets the mask
);

    // ------------------------------------------------------------
    // encoding
    // ------------------------------------------------------------
    wire logic [2:0] bool_code;          // true/false form
    wire logic [2:0] cmp_code;           // relation form

    assign bool_code = bool_true ? CC_TRUE : CC_FALSE;
    assign cmp_code  = cmp_lt ? CC_LT : cmp_eq ? CC_EQ : cmp_gt ? CC_GT : CC_UNORD;
    assign cc_write  = bool_valid | cmp_valid;
    assign cc_code   = cmp_valid ? cmp_code : bool_code;

    // ------------------------------------------------------------
    // test: unordered code 000 never meets any mask, so 111 means ordered
    // ------------------------------------------------------------
    assign test_hit  = |(cc_now & test_mask);

endmodule

// ---- rtl/acw_controls_word.sv ----
// acw_controls_word: the processor's 32-bit arithmetic controls word with its
// masked update, save/restore paths and the fault decisions that its masks steer.
// assumes: execution units present one-cycle requests synchronous to clock;
// a whole-word load and a save never need to be ordered inside one cycle.
module acw_controls_word
    import acw_pkg::*;
#(
    parameter int FP_FAULTS = FP_N       // floating-point flag/mask pairs
)
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    // masked update
    input  wire logic                 mod_valid,
    input  wire logic [31:0]          mod_mask,
    input  wire logic [31:0]          mod_value,
    output logic                      mod_done,
    output logic      [31:0]          mod_old,
    // whole-word restore: process bind or handler return
    input  wire logic                 load_valid,
    input  wire logic [31:0]          load_word,
    // whole-word save: process suspend or interrupt/fault entry
    input  wire logic                 save_req,
    output logic                      save_valid,
    output logic      [31:0]          save_word,
    // condition code writers and test
    input  wire logic                 bool_valid,
    input  wire logic                 bool_true,
    input  wire logic                 cmp_valid,
    input  wire logic                 cmp_gt,
    input  wire logic                 cmp_eq,
    input  wire logic                 cmp_lt,
    input  wire logic                 test_valid,
    input  wire logic [2:0]           test_mask,
    output logic                      test_done,
    output logic                      test_taken,
    // classify
    input  wire logic                 class_valid,
    input  wire logic                 class_sign,
    input  wire logic [2:0]           class_code,
    // arithmetic events
    input  wire logic                 int_ovf_event,
    input  wire logic [FP_FAULTS-1:0] fp_event,
    input  wire logic                 fp_denorm_event,
    output logic                      int_ovf_fault,
    output logic      [FP_FAULTS-1:0] fp_fault,
    output logic                      fp_resop_fault,
    // controls seen by the execution units
    output logic      [31:0]          word,
    output logic                      precise_faults,
    output logic                      normalize_en,
    output acw_round_t                round_mode
);

    // ------------------------------------------------------------
    // helper: replace the bits selected by sel
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] base,
                                          input logic [31:0] val,
                                          input logic [31:0] sel);
        merge = (base & ~sel) | (val & sel);
    endfunction

    // ------------------------------------------------------------
    // condition code unit
    // ------------------------------------------------------------
    wire logic       cc_write;          // a compare or boolean result this cycle
    wire logic [2:0] cc_code;           // its encoding
    wire logic       test_hit;          // branch test outcome on present code

    acw_cc_unit u_cc (
        .bool_valid (bool_valid),
        .bool_true  (bool_true),
        .cmp_valid  (cmp_valid),
        .cmp_gt     (cmp_gt),
        .cmp_eq     (cmp_eq),
        .cmp_lt     (cmp_lt),
        .cc_now     (word[CC_LSB +: CC_W]),
        .test_mask  (test_mask),
        .cc_write   (cc_write),
        .cc_code    (cc_code),
        .test_hit   (test_hit)
    );

    // ------------------------------------------------------------
    // field masks built once from the layout
    // ------------------------------------------------------------
    wire logic [31:0] cc_sel;           // condition code positions
    wire logic [31:0] as_sel;           // status positions
    wire logic [31:0] cc_put;           // code placed in position
    wire logic [31:0] as_put;           // class placed in position

    assign cc_sel = {{(32-CC_W){1'b0}}, {CC_W{1'b1}}} << CC_LSB;
    assign as_sel = {{(32-AS_W){1'b0}}, {AS_W{1'b1}}} << AS_LSB;
    assign cc_put = {29'h0, cc_code} << CC_LSB;
    assign as_put = {28'h0, class_sign, class_code} << AS_LSB;

    // ------------------------------------------------------------
    // fault gating: a set mask turns a fault into a sticky flag
    // ------------------------------------------------------------
    // decisions read the masks as held, so an update in the same cycle
    // only steers events from the next cycle on
    wire logic                 iov_masked;   // overflow seen while masked
    wire logic                 iov_raise;    // overflow seen while unmasked
    wire logic [FP_FAULTS-1:0] fp_masks;     // present float masks
    wire logic [FP_FAULTS-1:0] fp_masked;    // float events absorbed into flags
    wire logic [FP_FAULTS-1:0] fp_raise;     // float events that fault
    wire logic                 resop_raise;  // denormal operand refused

    assign iov_masked  = int_ovf_event &  word[IOV_MASK];
    assign iov_raise   = int_ovf_event & ~word[IOV_MASK];
    assign fp_masks    = word[FPM_LSB +: FP_FAULTS];
    assign fp_masked   = fp_event &  fp_masks;
    assign fp_raise    = fp_event & ~fp_masks;
    assign resop_raise = fp_denorm_event & ~word[NORM_BIT];

    // sticky sets laid out as word bits; a flag is only ever or-ed in
    wire logic [31:0] sticky_set;

    generate
        genvar gi;
        for (gi = 0; gi < 32; gi++) begin : g_sticky
            if (gi == IOV_FLAG) begin : g_iov
                assign sticky_set[gi] = iov_masked;
            end else if (gi >= FPF_LSB && gi < FPF_LSB + FP_FAULTS) begin : g_fp
                assign sticky_set[gi] = fp_masked[gi - FPF_LSB];
            end else begin : g_none
                assign sticky_set[gi] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // next word: restore, then masked update, then unit writes,
    // then sticky sets, which win over any clear in the same cycle
    // ------------------------------------------------------------
    wire logic [31:0] base_word;        // after restore
    wire logic [31:0] mod_word;         // after masked update
    wire logic [31:0] cc_word;          // after condition code write
    wire logic [31:0] as_word;          // after classify
    wire logic [31:0] next_word;        // stored next edge

    assign base_word = load_valid ? load_word : word;
    // a restore replaces the whole word, so an update in the same cycle is dropped
    assign mod_word  = (mod_valid && !load_valid) ?
                       merge(base_word, mod_value, mod_mask) : base_word;
    assign cc_word   = cc_write ? merge(mod_word, cc_put, cc_sel) : mod_word;
    assign as_word   = class_valid ? merge(cc_word, as_put, as_sel) : cc_word;
    // unused positions are forced to zero even if software breaks that promise
    assign next_word = (as_word | sticky_set) & ACW_USED_MASK;

    // ------------------------------------------------------------
    // the controls word itself
    // ------------------------------------------------------------
    // reset value is arbitrary: software is expected to load the word at start
    always_ff @(posedge clock) begin
        if (reset) begin
            word <= ACW_RESET;
        end else begin
            word <= next_word;
        end
    end

    // ------------------------------------------------------------
    // masked update answer: the word as it stood before the change
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            mod_done <= 1'b0;
            mod_old  <= ACW_RESET;
        end else begin
            mod_done <= mod_valid;
            if (mod_valid) begin
                mod_old <= word;
            end
        end
    end

    // ------------------------------------------------------------
    // save path for suspend and interrupt/fault records
    // ------------------------------------------------------------
    // the saved image excludes this cycle's updates, so a record holds
    // the state the interrupted code actually saw
    always_ff @(posedge clock) begin
        if (reset) begin
            save_valid <= 1'b0;
            save_word  <= ACW_RESET;
        end else begin
            save_valid <= save_req;
            if (save_req) begin
                save_word <= word;
            end
        end
    end

    // ------------------------------------------------------------
    // branch test result
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            test_done  <= 1'b0;
            test_taken <= 1'b0;
        end else begin
            test_done  <= test_valid;
            test_taken <= test_valid & test_hit;
        end
    end

    // ------------------------------------------------------------
    // fault pulses, one cycle after the event
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            int_ovf_fault  <= 1'b0;
            fp_fault       <= '0;
            fp_resop_fault <= 1'b0;
        end else begin
            int_ovf_fault  <= iov_raise;
            fp_fault       <= fp_raise;
            fp_resop_fault <= resop_raise;
        end
    end

    // ------------------------------------------------------------
    // control fields seen by the execution units, straight off the word
    // ------------------------------------------------------------
    assign precise_faults = word[NIF_BIT];
    assign normalize_en   = word[NORM_BIT];
    // all four codes are legal; 11 selects truncation toward zero
    assign round_mode     = acw_round_t'(word[RND_LSB +: RND_W]);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // every check below runs on the one clock and sleeps through reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    wire logic quiet_units;             // no unit writes a field this cycle
    assign quiet_units = !cc_write && !class_valid && !int_ovf_event && (fp_event == '0);

    // fields watched below, named once so their history can be sampled
    wire logic [FP_FAULTS-1:0] fp_flags;    // float sticky flags as held
    wire logic [CC_W-1:0]      cc_held;     // condition code as held
    assign fp_flags = word[FPF_LSB +: FP_FAULTS];
    assign cc_held  = word[CC_LSB +: CC_W];

    mod_keep_a: assert property (
        (mod_valid && !load_valid && quiet_units) |=>
        ((word & ~$past(mod_mask)) == ($past(word) & ~$past(mod_mask))) &&
        ((word & $past(mod_mask)) == ($past(mod_value) & $past(mod_mask) & ACW_USED_MASK)))
        else $error("masked update touched an unselected bit");

    mod_old_a: assert property (
        mod_valid |=> mod_done && (mod_old == $past(word)))
        else $error("masked update did not return the previous word");

    save_image_a: assert property (
        save_req |=> save_valid && (save_word == $past(word)))
        else $error("saved word differs from the word before the save");

    load_image_a: assert property (
        (load_valid && quiet_units) |=> word == ($past(load_word) & ACW_USED_MASK))
        else $error("restored word differs from the supplied image");

    sticky_hold_a: assert property (
        (word[IOV_FLAG] && !load_valid && !(mod_valid && mod_mask[IOV_FLAG])) |=>
        word[IOV_FLAG])
        else $error("integer-overflow flag cleared without software");

    cc_hold_a: assert property (
        (!cc_write && !load_valid && !(mod_valid && (mod_mask[2:0] != 3'h0))) |=>
        $stable(word[CC_LSB +: CC_W]))
        else $error("condition code changed with no writer");

    cmp_code_a: assert property (
        (cmp_valid && cmp_lt && !load_valid) |=> word[CC_LSB +: CC_W] == CC_LT)
        else $error("less-than compare stored the wrong code");

    bool_code_a: assert property (
        (bool_valid && !cmp_valid && !load_valid) |=>
        word[CC_LSB +: CC_W] == ($past(bool_true) ? CC_TRUE : CC_FALSE))
        else $error("boolean result stored the wrong code");

    class_store_a: assert property (
        (class_valid && !load_valid) |=>
        word[AS_LSB +: AS_W] == {$past(class_sign), $past(class_code)})
        else $error("classify stored the wrong status");

    iov_masked_a: assert property (
        (int_ovf_event && word[IOV_MASK]) |=> word[IOV_FLAG] && !int_ovf_fault)
        else $error("masked overflow faulted or left the flag clear");

    iov_fault_a: assert property (
        (int_ovf_event && !word[IOV_MASK]) |=> int_ovf_fault)
        else $error("unmasked overflow raised no fault");

    denorm_fault_a: assert property (
        fp_denorm_event |=> (fp_resop_fault == !$past(word[NORM_BIT])))
        else $error("denormal operand handling ignores normalizing mode");

    // a float flag may fall only by a whole-word restore or a software update
    fp_sticky_a: assert property (
        (!load_valid && !mod_valid) |=>
        ((fp_flags & $past(fp_flags)) == $past(fp_flags)))
        else $error("floating-point flag cleared without software");

    // a set mask turns its event into the flag; a clear mask lets it fault
    fp_masked_a: assert property (
        (fp_event != '0) |=>
        ((fp_fault & $past(fp_masks)) == '0) &&
        ((fp_fault | $past(fp_masks)) == ($past(fp_event) | $past(fp_masks))) &&
        ((fp_flags & $past(fp_event) & $past(fp_masks)) == ($past(fp_event) & $past(fp_masks))))
        else $error("float event ignored its mask");

    // a branch test reports on the code as it stood when the test was asked
    test_taken_a: assert property (
        test_valid |=>
        test_done && (test_taken == (($past(cc_held) & $past(test_mask)) != 3'h0)))
        else $error("branch test outcome disagrees with the held code");

endmodule

// ---- rtl/acw_pkg.sv ----
// acw_pkg: field layout, encodings and constants of the arithmetic controls word.
// assumes: shared by the controls word register and its condition-code unit.
package acw_pkg;

    // ------------------------------------------------------------
    // word geometry
    // ------------------------------------------------------------
    localparam int          ACW_WIDTH     = 32;            // whole controls word
    localparam logic [31:0] ACW_USED_MASK = 32'hff1f_917f; // unused positions read as zero
    localparam logic [31:0] ACW_RESET     = 32'h0000_0000; // arbitrary: word is undefined at start

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CC_LSB     = 0;   // condition code, three bits
    localparam int CC_W       = 3;
    localparam int AS_LSB     = 3;   // arithmetic status, four bits, top bit is sign
    localparam int AS_W       = 4;
    localparam int IOV_FLAG   = 8;   // integer-overflow sticky flag
    localparam int IOV_MASK   = 12;  // integer-overflow fault mask
    localparam int NIF_BIT    = 15;  // no-imprecise-faults control
    localparam int FPF_LSB    = 16;  // floating-point sticky flags
    localparam int FPM_LSB    = 24;  // floating-point fault masks
    localparam int FP_N       = 5;   // flag/mask pairs
    localparam int NORM_BIT   = 29;  // normalizing mode
    localparam int RND_LSB    = 30;  // rounding field, two bits
    localparam int RND_W      = 2;

    // ------------------------------------------------------------
    // condition-code values and test masks
    // ------------------------------------------------------------
    localparam logic [2:0] CC_FALSE   = 3'h0;
    localparam logic [2:0] CC_TRUE    = 3'h2;
    localparam logic [2:0] CC_UNORD   = 3'h0;
    localparam logic [2:0] CC_GT      = 3'h1;
    localparam logic [2:0] CC_EQ      = 3'h2;
    localparam logic [2:0] CC_LT      = 3'h4;
    localparam logic [2:0] TEST_GE    = 3'h3;
    localparam logic [2:0] TEST_LE    = 3'h6;
    localparam logic [2:0] TEST_NE    = 3'h5;
    localparam logic [2:0] TEST_ORD   = 3'h7;

    // ------------------------------------------------------------
    // operand classes (low three bits of the status field)
    // ------------------------------------------------------------
    localparam logic [2:0] CLS_ZERO    = 3'h0;
    localparam logic [2:0] CLS_DENORM  = 3'h1;
    localparam logic [2:0] CLS_NORMAL  = 3'h2;
    localparam logic [2:0] CLS_INF     = 3'h3;
    localparam logic [2:0] CLS_QNAN    = 3'h4;
    localparam logic [2:0] CLS_SNAN    = 3'h5;
    localparam logic [2:0] CLS_RESOP   = 3'h6;

    // rounding modes as held in the rounding field
    typedef enum logic [1:0] {
        ACW_RND_NEAREST  = 2'h0,
        ACW_RND_DOWN     = 2'h1,
        ACW_RND_UP       = 2'h2,
        ACW_RND_TRUNCATE = 2'h3
    } acw_round_t;

endpackage

// ---- tb/acw_partner.sv ----
// acw_partner: kernel-side record store, the place where a saved controls word
// is kept across a suspend, interrupt or fault and handed back for the restore.
// assumes: one save pulse at a time; the record is only read by the bench.
module acw_partner
    import acw_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        save_valid,
    input  wire logic [31:0] save_word,
    output logic      [31:0] record
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // record keeping
    // ------------------------------------------------------------
    // the image is stored with reserved positions forced low, as software must
    always_ff @(posedge clock) begin
        if (save_valid) begin
            record <= save_word & ACW_USED_MASK;
        end
    end
endmodule

// ---- tb/arithmetic_controls_word_tb.sv ----
// arithmetic_controls_word_tb: drives the controls word through its request
// pulses and compares the word and fault outputs with values from the encodings.
// assumes: every request is answered one cycle later; 100 MHz clock.
module arithmetic_controls_word_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acw_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clock, reset, mod_valid, load_valid, save_req, bool_valid, bool_true;
    logic cmp_valid, cmp_gt, cmp_eq, cmp_lt, test_valid, class_valid, class_sign;
    logic int_ovf_event, fp_denorm_event, mod_done, save_valid, branch_done, test_taken;
    logic int_ovf_fault, fp_resop_fault, precise_faults, normalize_en;
    logic [31:0] mod_mask, mod_value, load_word, mod_old, save_word, word, record;
    logic [2:0]  test_mask, class_code;
    logic [4:0]  fp_event, fp_fault;
    acw_round_t  round_mode;
    int          errors, check_count;

    acw_controls_word u_acw_controls_word (.clock, .reset, .mod_valid, .mod_mask,
        .mod_value, .mod_done, .mod_old, .load_valid, .load_word, .save_req,
        .save_valid, .save_word, .bool_valid, .bool_true, .cmp_valid, .cmp_gt,
        .cmp_eq, .cmp_lt, .test_valid, .test_mask, .test_done(branch_done), .test_taken,
        .class_valid, .class_sign, .class_code, .int_ovf_event, .fp_event,
        .fp_denorm_event, .int_ovf_fault, .fp_fault, .fp_resop_fault, .word,
        .precise_faults, .normalize_en, .round_mode);
    acw_partner u_acw_partner (.clock, .save_valid, .save_word, .record);

    // free-running clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // let the request edge pass, drop every pulse, then sample settled outputs
    task automatic step;
        @(posedge clock);
        {mod_valid, load_valid, save_req, bool_valid, cmp_valid} <= '0;
        {test_valid, class_valid, int_ovf_event, fp_denorm_event} <= '0;
        fp_event <= '0;
        #1;
    endtask
    task automatic modac(input logic [31:0] m, input logic [31:0] v);
        @(posedge clock);
        mod_valid <= 1'b1;
        mod_mask  <= m;
        mod_value <= v;
        step;
    endtask
    task automatic load(input logic [31:0] v);
        @(posedge clock);
        load_valid <= 1'b1;
        load_word  <= v;
        step;
    endtask
    task automatic test_done;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        errors++;
        test_done;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset, mod_valid, load_valid, save_req, bool_valid, bool_true, cmp_valid} = '1;
        {mod_valid, load_valid, save_req, bool_valid, bool_true, cmp_valid} = '0;
        {cmp_gt, cmp_eq, cmp_lt, test_valid, class_valid, class_sign} = '0;
        {int_ovf_event, fp_denorm_event, fp_event, test_mask, class_code} = '0;
        {mod_mask, mod_value, load_word} = '0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        load(ACW_USED_MASK);
        chk(word, ACW_USED_MASK);
        chk({precise_faults, normalize_en, round_mode}, 4'hf);
        modac(32'hc000_0001, 32'h4000_0000);
        chk(mod_old, ACW_USED_MASK);
        chk(word, ACW_USED_MASK & 32'h7fff_fffe);
        for (int r = 0; r < 3; r++) begin
            modac(32'hc000_0000, 32'(r) << 30);
            chk(round_mode, r);
        end
        modac(32'hffff_ffff, 32'h0000_1000);
        @(posedge clock);
        int_ovf_event <= 1'b1;
        step;
        chk({int_ovf_fault, word}, 33'h0_0000_1100);
        modac(32'h0000_1000, 32'h0);
        @(posedge clock);
        int_ovf_event <= 1'b1;
        step;
        chk({int_ovf_fault, word}, 33'h1_0000_0100);
        modac(32'hffff_ffff, 32'h0100_0000);
        @(posedge clock);
        fp_event <= 5'h03;
        fp_denorm_event <= 1'b1;
        step;
        chk({fp_fault, fp_resop_fault, word}, {5'h02, 1'b1, 32'h0101_0000});
        modac(32'h2000_0000, 32'h2000_0000);
        @(posedge clock);
        fp_denorm_event <= 1'b1;
        step;
        chk(fp_resop_fault, 1'b0);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            {cmp_lt, cmp_eq, cmp_gt} <= (i < 4) ? 3'(1 << i) & 3'h7 : '0;
            cmp_valid  <= (i < 4);
            bool_valid <= (i >= 4);
            bool_true  <= (i == 4);
            step;
            chk(word[2:0], (i == 0) ? CC_GT : (i == 1) ? CC_EQ : (i == 2) ? CC_LT
                : (i == 3) ? CC_UNORD : (i == 4) ? CC_TRUE : CC_FALSE);
        end
        @(posedge clock);
        {cmp_valid, cmp_lt} <= 2'h3;
        step;
        for (int t = 0; t < 4; t++) begin
            @(posedge clock);
            test_valid <= 1'b1;
            test_mask  <= (t == 0) ? TEST_GE : (t == 1) ? TEST_LE : (t == 2) ? TEST_NE : TEST_ORD;
            step;
            chk({branch_done, test_taken}, {1'b1, t != 0});
        end
        for (int c = 0; c < 7; c++) begin
            @(posedge clock);
            class_valid <= 1'b1;
            class_sign  <= c[0];
            class_code  <= 3'(c);
            step;
            chk(word[6:0], {c[0], 3'(c), CC_LT});
        end
        @(posedge clock);
        save_req <= 1'b1;
        step;
        chk({save_valid, save_word}, {1'b1, 32'h2101_0034});
        modac(32'hffff_ffff, 32'h0);
        chk(mod_done, 1'b1);
        load(record);
        chk(word, 32'h2101_0034);
        test_done;
    end
endmodule
